// File: src/rcp_ranging_params.sv
// ranging command parameter block: registers, latching, sequencing, pins
`timescale 1ns/100ps
`default_nettype none
module rcp_ranging_params
  import rcp_pkg::*;
#(
  parameter int MS_CYCLES = PERIOD_CYC
)(
  // clock, reset, enable
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // register port
  input  wire logic [7:0]    addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [7:0]    rdata,
  // general pins
  input  wire logic [1:0]    gpin_in,
  output logic      [1:0]    gpin_out,
  output logic      [1:0]    gpin_oe,
  // sensor core
  output rcp_pkg::rcp_core_cfg_t core_cfg,
  output logic               core_start,
  output logic               core_abort,
  input  wire logic          core_emit_req,
  output logic               core_emit_fire,
  input  wire logic          core_done,
  // completion
  output logic               irq
);

  typedef enum logic [1:0] {
    RCP_IDLE,
    RCP_RUN,
    RCP_WAIT,
    RCP_HOLD
  } rcp_state_t;

  // host-side parameter bytes and their latched copy
  rcp_param_t    param_reg, param_next;
  rcp_param_t    live_reg, live_next;
  logic [7:0]    command_reg, command_next;
  logic [7:0]    control_reg, control_next;
  logic [7:0]    rdata_reg, rdata_next;

  // sequencer state
  rcp_state_t    state_reg, state_next;
  logic [7:0]    tid_reg, tid_next;
  logic          irq_reg, irq_next;
  logic          start_reg, start_next;
  logic          abort_reg, abort_next;
  logic [7:0]    elapsed_reg, elapsed_next;
  logic [15:0]   ms_cnt_reg, ms_cnt_next;
  rcp_core_cfg_t cfg_reg, cfg_next;

  // pins
  logic [1:0]    pin_inhibit;
  logic          inhibit_any;
  logic          pulse_mode;
  logic          pulse_level;
  logic          measure_cmd;
  logic          period_met;

  assign measure_cmd = wr && addr == ADDR_COMMAND && wdata == CMD_MEASURE;

  // register writes and read data
  always_comb begin
    param_next   = param_reg;
    command_next = command_reg;
    control_next = control_reg;
    rdata_next   = BYTE_ZERO;
    if (wr) begin
      case (addr)
        ADDR_COMMAND:    command_next            = wdata;
        ADDR_ITER_HIGH:  param_next.iter_high     = wdata;
        ADDR_ITER_LOW:   param_next.iter_low      = wdata;
        ADDR_REPEAT:     param_next.repeat_period = wdata;
        ADDR_THRESHOLD:  param_next.thr_spread    = wdata;
        ADDR_PULSE_LEAD: param_next.pulse_lead    = wdata;
        ADDR_PIN_FUNC:   param_next.pin_func      = wdata;
        ADDR_ALG_MASK:   param_next.alg_mask      = wdata;
        ADDR_CONTROL:    control_next            = wdata;
        default: begin
        end
      endcase
    end
    if (rd) begin
      case (addr)
        ADDR_COMMAND:    rdata_next = command_reg;
        ADDR_ITER_HIGH:  rdata_next = param_reg.iter_high;
        ADDR_ITER_LOW:   rdata_next = param_reg.iter_low;
        ADDR_REPEAT:     rdata_next = param_reg.repeat_period;
        ADDR_THRESHOLD:  rdata_next = param_reg.thr_spread;
        ADDR_PULSE_LEAD: rdata_next = param_reg.pulse_lead;
        ADDR_PIN_FUNC:   rdata_next = param_reg.pin_func;
        ADDR_ALG_MASK:   rdata_next = param_reg.alg_mask;
        ADDR_CONTROL:    rdata_next = control_reg;
        ADDR_STATUS:     rdata_next = {4'h0, inhibit_any, 1'b0, state_reg};
        ADDR_TID:        rdata_next = tid_reg;
        // unmapped addresses read as zero
        default:         rdata_next = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      param_reg   <= '{alg_mask: ALG_MASK_RESET, pin_func: PIN_FUNC_RESET, default: BYTE_ZERO};
      command_reg <= BYTE_ZERO;
      control_reg <= BYTE_ZERO;
      rdata_reg   <= BYTE_ZERO;
    end else if (ce) begin
      param_reg   <= param_next;
      command_reg <= command_next;
      control_reg <= control_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // pin decode; the two pins share one lead timer since the emitter is shared
  assign pulse_mode = live_reg.pin_func[3:0] == PIN_PULSE
                   || live_reg.pin_func[7:4] == PIN_PULSE;

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    rcp_pin_ctrl u_pin (
      .func        (live_reg.pin_func[p*PIN_FIELD_W +: PIN_FIELD_W]),
      .pulse_level (pulse_level),
      .pin_in      (gpin_in[p]),
      .pin_out     (gpin_out[p]),
      .pin_oe      (gpin_oe[p]),
      .inhibit     (pin_inhibit[p])
    );
  end

  assign inhibit_any = |pin_inhibit;

  rcp_lead_timer u_lead (
    .clock    (clock),
    .rst_n    (rst_n),
    .ce       (ce),
    .enable   (pulse_mode),
    .lead     (live_reg.pulse_lead),
    .emit_req (core_emit_req),
    .level    (pulse_level),
    .fire     (core_emit_fire)
  );

  // best effort: if the period already ran out during ranging, restart at once
  assign period_met = elapsed_reg >= live_reg.repeat_period;

  // measurement sequencer
  always_comb begin
    live_next    = live_reg;
    cfg_next     = cfg_reg;
    state_next   = state_reg;
    tid_next     = tid_reg;
    irq_next     = 1'b0;
    start_next   = 1'b0;
    abort_next   = 1'b0;
    elapsed_next = elapsed_reg;
    ms_cnt_next  = ms_cnt_reg;
    if (ms_cnt_reg == 16'(MS_CYCLES - 1)) begin
      ms_cnt_next = 16'h0000;
      if (elapsed_reg != 8'hFF) begin
        elapsed_next = elapsed_reg + 8'h01;
      end
    end else begin
      ms_cnt_next = ms_cnt_reg + 16'h0001;
    end
    if (core_done && state_reg == RCP_RUN) begin
      tid_next = tid_reg + 8'h01;
      irq_next = control_reg[IRQ_EN_BIT];
    end
    if (measure_cmd) begin
      live_next = param_reg;
      cfg_next.threshold           = param_reg.thr_spread[THR_MSB:0];
      cfg_next.spread_spectrum     = param_reg.thr_spread[SPREAD_BIT];
      cfg_next.emitter_clock_halve = param_reg.alg_mask[HALVE_BIT];
      cfg_next.alg_mask            = param_reg.alg_mask;
      cfg_next.iterations = {param_reg.iter_high, param_reg.iter_low, 10'h000};
      abort_next   = state_reg == RCP_RUN;
      state_next   = RCP_RUN;
      start_next   = 1'b1;
      elapsed_next = BYTE_ZERO;
      ms_cnt_next  = 16'h0000;
    end else begin
      case (state_reg)
        RCP_IDLE: begin
        end
        RCP_RUN: begin
          if (inhibit_any) begin
            state_next = RCP_HOLD;
            abort_next = 1'b1;
          end else if (core_done) begin
            if (live_reg.repeat_period == BYTE_ZERO) begin
              state_next = RCP_IDLE;
            end else if (period_met) begin
              start_next   = 1'b1;
              elapsed_next = BYTE_ZERO;
              ms_cnt_next  = 16'h0000;
            end else begin
              state_next = RCP_WAIT;
            end
          end
        end
        RCP_WAIT: begin
          if (inhibit_any) begin
            state_next = RCP_HOLD;
          end else if (period_met) begin
            state_next   = RCP_RUN;
            start_next   = 1'b1;
            elapsed_next = BYTE_ZERO;
            ms_cnt_next  = 16'h0000;
          end
        end
        RCP_HOLD: begin
          if (!inhibit_any) begin
            state_next   = RCP_RUN;
            start_next   = 1'b1;
            elapsed_next = BYTE_ZERO;
            ms_cnt_next  = 16'h0000;
          end
        end
        default: begin
          state_next = RCP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      live_reg    <= '{alg_mask: ALG_MASK_RESET, pin_func: PIN_FUNC_RESET, default: BYTE_ZERO};
      cfg_reg     <= '0;
      state_reg   <= RCP_IDLE;
      tid_reg     <= BYTE_ZERO;
      irq_reg     <= 1'b0;
      start_reg   <= 1'b0;
      abort_reg   <= 1'b0;
      elapsed_reg <= BYTE_ZERO;
      ms_cnt_reg  <= 16'h0000;
    end else if (ce) begin
      live_reg    <= live_next;
      cfg_reg     <= cfg_next;
      state_reg   <= state_next;
      tid_reg     <= tid_next;
      irq_reg     <= irq_next;
      start_reg   <= start_next;
      abort_reg   <= abort_next;
      elapsed_reg <= elapsed_next;
      ms_cnt_reg  <= ms_cnt_next;
    end
  end

  assign core_cfg   = cfg_reg;
  assign core_start = start_reg;
  assign core_abort = abort_reg;
  assign irq        = irq_reg;

  // checks
  a_tid_on_done: assert property (@(posedge clock) disable iff (!rst_n)
    ce && core_done && state_reg == RCP_RUN && !measure_cmd |=> tid_reg == $past(tid_reg) + 8'h01)
    else $error("transaction counter did not advance on completion");

  a_irq_enabled: assert property (@(posedge clock) disable iff (!rst_n)
    ce && core_done && state_reg == RCP_RUN && control_reg[IRQ_EN_BIT] |=> irq)
    else $error("interrupt missing on enabled completion");

  a_irq_masked: assert property (@(posedge clock) disable iff (!rst_n)
    irq |-> $past(core_done) && $past(control_reg[IRQ_EN_BIT]))
    else $error("interrupt without enabled completion");

  a_latch_params: assert property (@(posedge clock) disable iff (!rst_n)
    ce && measure_cmd |=> live_reg == $past(param_reg)
      && core_cfg.iterations == {$past(param_reg.iter_high), $past(param_reg.iter_low), 10'h000})
    else $error("parameters not latched on measure command");

  a_single_shot: assert property (@(posedge clock) disable iff (!rst_n)
    ce && state_reg == RCP_RUN && core_done && !inhibit_any && !measure_cmd
      && live_reg.repeat_period == BYTE_ZERO |=> state_reg == RCP_IDLE && !core_start)
    else $error("single measurement did not stop");

  a_best_effort: assert property (@(posedge clock) disable iff (!rst_n)
    ce && state_reg == RCP_RUN && core_done && !inhibit_any && !measure_cmd
      && live_reg.repeat_period != BYTE_ZERO && period_met |=> core_start)
    else $error("overdue repeat not restarted at once");

  a_inhibit_abort: assert property (@(posedge clock) disable iff (!rst_n)
    ce && state_reg == RCP_RUN && inhibit_any && !measure_cmd
      |=> core_abort && state_reg == RCP_HOLD)
    else $error("stop pin did not abort the measurement");

  a_release_start: assert property (@(posedge clock) disable iff (!rst_n)
    ce && state_reg == RCP_HOLD && !inhibit_any && !measure_cmd
      |=> core_start && state_reg == RCP_RUN)
    else $error("stop pin release did not restart");

  a_pin_drive: assert property (@(posedge clock) disable iff (!rst_n)
    live_reg.pin_func[3:0] == PIN_DRIVE_LOW |-> gpin_oe[0] && !gpin_out[0])
    else $error("pin zero not driven low");

  a_fall_fire: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(core_emit_fire) && $past(pulse_level) |-> !pulse_level)
    else $error("indicator still high when emitter fires");

  a_lead_one: assert property (@(posedge clock) disable iff (!rst_n)
    ce && pulse_mode && core_emit_req && !pulse_level && !core_emit_fire
      && live_reg.pulse_lead == 8'h01 |=> pulse_level ##1 core_emit_fire)
    else $error("lead of one did not fire after one cycle");

endmodule // rcp_ranging_params
`default_nettype wire

// File: src/rcp_pkg.sv
// package: constants, register map and carriers for the ranging command parameter block
// Behaviour
// - pin zero function is bits 3:0 of pin function byte; code 0 is input.
// - code 1, low level aborts and blocks measuring; rising back starts anew.
// - code 2, high level aborts and blocks measuring; falling back starts anew.
// - code 3 drives the pin as emitter pulse indicator, timed by lead byte.
// - code 4 drives low, the startup state; code 5 drives high.
// - pin one function is bits 7:4, same codes as pin zero.
// - lead byte only matters when some pin is in indicator mode.
// - lead 0 no signal, 1 rises 0 us before, each step adds 100 us.
// - indicator falls exactly when the emitter starts emitting.
// - threshold is bits 5:0, default 0; bit 7 written as zero.
// - threshold byte bit 6 enables spread spectrum mode.
// - repeat byte is period in ms; 0 means one single measurement.
// - period shorter than ranging time means repeat as fast as possible.
// - iteration low byte counts in units of 1 k iterations.
// - iteration high byte counts in units of 256 k iterations.
// - each finished measurement raises the interrupt only if enabled.
// - each finished measurement advances the transaction counter.
package rcp_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_COMMAND    = 8'h10;
  localparam logic [7:0] ADDR_ITER_HIGH  = 8'h14;
  localparam logic [7:0] ADDR_ITER_LOW   = 8'h18;
  localparam logic [7:0] ADDR_REPEAT     = 8'h1C;
  localparam logic [7:0] ADDR_THRESHOLD  = 8'h20;
  localparam logic [7:0] ADDR_PULSE_LEAD = 8'h24;
  localparam logic [7:0] ADDR_PIN_FUNC   = 8'h28;
  localparam logic [7:0] ADDR_ALG_MASK   = 8'h2C;
  localparam logic [7:0] ADDR_CONTROL    = 8'h30;
  localparam logic [7:0] ADDR_STATUS     = 8'h34;
  localparam logic [7:0] ADDR_TID        = 8'h38;

  // command value that starts a measurement sequence
  localparam logic [7:0] CMD_MEASURE     = 8'h02;

  // reset values
  localparam logic [7:0] PIN_FUNC_RESET  = 8'h44;
  localparam logic [7:0] ALG_MASK_RESET  = 8'h03;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;

  // field positions
  localparam int PIN_FIELD_W  = 4;
  localparam int THR_MSB      = 5;
  localparam int SPREAD_BIT   = 6;
  localparam int HALVE_BIT    = 2;
  localparam int IRQ_EN_BIT   = 0;
  localparam int ITER_SHIFT   = 10;
  localparam int ITER_W       = 26;
  localparam int NUM_PINS     = 2;

  // pin function codes
  localparam logic [3:0] PIN_INPUT      = 4'h0;
  localparam logic [3:0] PIN_STOP_LOW   = 4'h1;
  localparam logic [3:0] PIN_STOP_HIGH  = 4'h2;
  localparam logic [3:0] PIN_PULSE      = 4'h3;
  localparam logic [3:0] PIN_DRIVE_LOW  = 4'h4;
  localparam logic [3:0] PIN_DRIVE_HIGH = 4'h5;

  // timing
  localparam int CLOCK_KHZ      = 20000;
  localparam int LEAD_STEP_US   = 100;
  localparam int LEAD_STEP_CYC  = (LEAD_STEP_US * CLOCK_KHZ) / 1000;
  localparam int PERIOD_UNIT_MS = 1;
  localparam int PERIOD_CYC     = PERIOD_UNIT_MS * CLOCK_KHZ;

  // parameter bytes as written by the host
  typedef struct packed {
    logic [7:0] alg_mask;
    logic [7:0] pin_func;
    logic [7:0] pulse_lead;
    logic [7:0] thr_spread;
    logic [7:0] repeat_period;
    logic [7:0] iter_low;
    logic [7:0] iter_high;
  } rcp_param_t;

  // settings handed to the sensor core
  typedef struct packed {
    logic [5:0]        threshold;
    logic              spread_spectrum;
    logic              emitter_clock_halve;
    logic [ITER_W-1:0] iterations;
    logic [7:0]        alg_mask;
  } rcp_core_cfg_t;

endpackage

// File: src/rcp_pin_ctrl.sv
// one general pin: function decode, drive and stop detection
`timescale 1ns/100ps
`default_nettype none
module rcp_pin_ctrl
  import rcp_pkg::*;
(
  // function and sources
  input  wire logic [3:0] func,
  input  wire logic       pulse_level,
  // pin signals
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe,
  // stop request towards the sequencer
  output logic            inhibit
);

  always_comb begin
    pin_out = 1'b0;
    pin_oe  = 1'b0;
    inhibit = 1'b0;
    case (func)
      PIN_INPUT: begin
        pin_oe = 1'b0;
      end
      PIN_STOP_LOW: begin
        inhibit = !pin_in;
      end
      PIN_STOP_HIGH: begin
        inhibit = pin_in;
      end
      PIN_PULSE: begin
        pin_oe  = 1'b1;
        pin_out = pulse_level;
      end
      PIN_DRIVE_LOW: begin
        pin_oe  = 1'b1;
        pin_out = 1'b0;
      end
      PIN_DRIVE_HIGH: begin
        pin_oe  = 1'b1;
        pin_out = 1'b1;
      end
      // reserved codes leave the pin floating as an input
      default: begin
        pin_oe = 1'b0;
      end
    endcase
  end

endmodule // rcp_pin_ctrl
`default_nettype wire

// File: src/rcp_lead_timer.sv
// emitter pulse indicator: raises the pin ahead of the emitter and releases it
`timescale 1ns/100ps
`default_nettype none
module rcp_lead_timer
  import rcp_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // control
  input  wire logic       enable,
  input  wire logic [7:0] lead,
  input  wire logic       emit_req,
  // results
  output logic            level,
  output logic            fire
);

  logic [7:0]  steps_reg, steps_next;
  logic [11:0] cyc_reg, cyc_next;
  logic        busy_reg, busy_next;
  logic        level_reg, level_next;
  logic        fire_reg, fire_next;

  always_comb begin
    steps_next = steps_reg;
    cyc_next   = cyc_reg;
    busy_next  = busy_reg;
    level_next = level_reg;
    fire_next  = 1'b0;
    if (!busy_reg && emit_req) begin
      if (!enable || lead == BYTE_ZERO) begin
        fire_next = 1'b1;
      end else begin
        busy_next  = 1'b1;
        level_next = 1'b1;
        steps_next = lead - 8'h01;
        cyc_next   = 12'h000;
      end
    end else if (busy_reg) begin
      if (steps_reg == BYTE_ZERO) begin
        busy_next  = 1'b0;
        level_next = 1'b0;
        fire_next  = 1'b1;
      end else if (cyc_reg == 12'(LEAD_STEP_CYC - 1)) begin
        cyc_next   = 12'h000;
        steps_next = steps_reg - 8'h01;
      end else begin
        cyc_next = cyc_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      steps_reg <= 8'h00;
      cyc_reg   <= 12'h000;
      busy_reg  <= 1'b0;
      level_reg <= 1'b0;
      fire_reg  <= 1'b0;
    end else if (ce) begin
      steps_reg <= steps_next;
      cyc_reg   <= cyc_next;
      busy_reg  <= busy_next;
      level_reg <= level_next;
      fire_reg  <= fire_next;
    end
  end

  assign level = level_reg;
  assign fire  = fire_reg;

endmodule // rcp_lead_timer
`default_nettype wire

// File: testbench/rcp_core_model.sv
// sensor core stand-in: asks for the emitter after a start, finishes after the fire
`timescale 1ns/100ps
`default_nettype none
module rcp_core_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // block side
  input  wire logic core_start,
  input  wire logic core_abort,
  input  wire logic core_emit_fire,
  input  wire logic slow,
  output logic      core_emit_req,
  output logic      core_done
);
  int cnt_reg;
  // slow runs outlast one period unit, so a 1 ms period is always overdue
  always_ff @(posedge clock) begin
    core_emit_req <= 1'b0;
    core_done     <= core_emit_fire && cnt_reg == 0;
    if (!rst_n) begin
      cnt_reg   <= -1;
      core_done <= 1'b0;
    end else if (core_start) begin
      // a restart arrives together with an abort and must not be lost behind it
      cnt_reg   <= slow ? 40 : 3;
      core_done <= 1'b0;
    end else if (core_abort) begin
      cnt_reg   <= -1;
      core_done <= 1'b0;
    end else if (core_emit_fire && cnt_reg == 0) begin
      cnt_reg <= -1;
    end else if (cnt_reg > 0) begin
      cnt_reg       <= cnt_reg - 1;
      core_emit_req <= cnt_reg == 1;
    end
  end
endmodule // rcp_core_model
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the ranging command parameter block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rcp_pkg::*;
  logic          clock, rst_n, wr, rd, slow, irq, core_start, core_abort, core_emit_req;
  logic          core_emit_fire, core_done, done_d, rd_pend, irq_en, fast, ce;
  logic [7:0]    addr, wdata, rdata, p_thr, p_hi, p_lo, lead;
  logic [1:0]    gpin_in, gpin_out, gpin_oe, mask, pin_d;
  rcp_core_cfg_t core_cfg;
  int            fails, samples_checked, starts, aborts, dones, lat, exp_lat, gap, exp_gap, n;
  int            snap;
  logic [7:0]    rd_q[$];

  rcp_ranging_params #(.MS_CYCLES(20)) dut_u (.clock(clock), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gpin_in(gpin_in),
    .gpin_out(gpin_out), .gpin_oe(gpin_oe), .core_cfg(core_cfg), .core_start(core_start),
    .core_abort(core_abort), .core_emit_req(core_emit_req), .core_emit_fire(core_emit_fire),
    .core_done(core_done), .irq(irq));
  rcp_core_model core_u (.clock(clock), .rst_n(rst_n), .core_start(core_start),
    .core_abort(core_abort), .core_emit_fire(core_emit_fire), .slow(slow),
    .core_emit_req(core_emit_req), .core_done(core_done));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // the expected byte is noted now and compared when the answer appears
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clock);
    addr <= a; rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    cyc(2);
  endtask

  task automatic measure(input logic [7:0] pins, input logic [7:0] per);
    wr_reg(ADDR_PIN_FUNC, pins);
    wr_reg(ADDR_REPEAT, per);
    wr_reg(ADDR_COMMAND, CMD_MEASURE);
  endtask

  always @(posedge clock) begin
    rd_pend <= rd;
    done_d  <= core_done & rst_n;
    dones   <= dones + int'(done_d);
    aborts  <= aborts + int'(core_abort);
    pin_d   <= gpin_out & gpin_oe & mask;
    lat     <= core_emit_req ? 1 : lat + 1;
    if (rd_pend) chk(rdata, rd_q.pop_front());
    if (done_d) chk(irq, irq_en);
    if (done_d && fast) chk(core_start, 1'b1);
    if (core_start) begin
      if (exp_gap != 0) chk(gap >= exp_gap && gap <= exp_gap + 1, 1'b1);
      gap    <= 1;
      starts <= starts + 1;
    end else begin
      gap <= gap + 1;
    end
    if (core_emit_fire) begin
      chk(lat, exp_lat);
      chk(gpin_out & gpin_oe & mask, 2'b00);
      chk(pin_d, (lead != 0) ? mask : 2'b00);
    end
  end

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    test_done();
  end

  initial begin
    {rst_n, wr, rd, slow, irq_en, fast, mask, addr, wdata, lead} = '0;
    {starts, aborts, dones, fails, samples_checked, exp_gap, gap} = '0;
    exp_lat = 1;
    ce = 1'b1;
    gpin_in = 2'b01;
    void'($urandom(32'h71CA2125));
    cyc(16);
    rst_n <= 1'b1;
    cyc(2);
    chk(gpin_oe, 2'b11);
    chk(gpin_out, 2'b00);
    rd_reg(ADDR_PIN_FUNC, 8'h44);
    rd_reg(ADDR_ALG_MASK, 8'h03);
    rd_reg(ADDR_TID, 8'h00);
    rd_reg(8'h3C, 8'h00);
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    wr_reg(ADDR_PIN_FUNC, 8'h11);
    ce <= 1'b1;
    rd_reg(ADDR_PIN_FUNC, 8'h44);
    // emitter indicator: both pins, then a lead with no indicator pin
    for (n = 0; n < 4; n++) begin
      lead    = (n == 3) ? 8'h05 : n[7:0];
      mask    = (n == 3) ? 2'b00 : 2'b11;
      exp_lat = (lead == 0 || n == 3) ? 1 : 2 + (lead - 1) * LEAD_STEP_CYC;
      wr_reg(ADDR_PULSE_LEAD, lead);
      measure((n == 3) ? 8'h44 : 8'h33, 8'h00);
      cyc(4100);
    end
    mask    = 2'b00;
    exp_lat = 1;
    for (n = 0; n < 3; n++) begin
      p_thr  = 8'($urandom) & 8'h7F;
      p_hi   = 8'($urandom);
      p_lo   = 8'($urandom);
      irq_en = 1'($urandom);
      wr_reg(ADDR_CONTROL, {7'h00, irq_en});
      wr_reg(ADDR_THRESHOLD, p_thr);
      wr_reg(ADDR_ITER_HIGH, p_hi);
      wr_reg(ADDR_ITER_LOW, p_lo);
      wr_reg(ADDR_ALG_MASK, {5'h00, p_thr[6], 2'b11});
      snap = starts;
      measure(8'h54, 8'h00);
      wr_reg(ADDR_THRESHOLD, ~p_thr & 8'h3F);
      chk(core_cfg.threshold, p_thr[5:0]);
      chk(core_cfg.spread_spectrum, p_thr[6]);
      chk(core_cfg.emitter_clock_halve, p_thr[6]);
      chk(core_cfg.iterations, {p_hi, p_lo, 10'h000});
      chk(core_cfg.alg_mask, {5'h00, p_thr[6], 2'b11});
      chk({gpin_oe, gpin_out}, 4'hE);
      cyc(60);
      chk(starts - snap, 1);
    end
    measure(8'h00, 8'h00);
    cyc(20);
    chk(gpin_oe, 2'b00);
    // stop pins: zero stops on low, one stops on high
    slow <= 1'b1;
    measure(8'h21, 8'h00);
    cyc(5);
    n = aborts;
    gpin_in <= 2'b00;
    cyc(3);
    chk(aborts - n, 1);
    rd_reg(ADDR_STATUS, 8'h0B);
    n = starts;
    gpin_in <= 2'b01;
    cyc(3);
    chk(starts - n, 1);
    n = aborts;
    gpin_in <= 2'b11;
    cyc(3);
    chk(aborts - n, 1);
    n = starts;
    gpin_in <= 2'b01;
    cyc(3);
    chk(starts - n, 1);
    // overdue period restarts at once; a longer period waits for it
    fast <= 1'b1;
    measure(8'h44, 8'h01);
    cyc(200);
    fast <= 1'b0;
    slow <= 1'b0;
    measure(8'h44, 8'h02);
    cyc(3);
    exp_gap = 40;
    cyc(130);
    exp_gap = 0;
    measure(8'h44, 8'h00);
    cyc(30);
    rd_reg(ADDR_TID, 8'(dones));
    test_done();
  end
endmodule // testbench
`default_nettype wire
